// [bdc_codec.sv]
`timescale 1ns/1ps
// Summary of operation
// - A decimal digit is four bits; only codes zero to nine are valid.
// - Unpacked decimal digit value comes only from the byte's low nibble.
// - Packed byte holds two digits; the high nibble is more significant.
// - Eighteen digits in bytes zero to eight, least significant at bottom.
// - Top bit of the last byte is the sign; its low seven bits ignored.
// - Negative values are sign-magnitude, never two's complement.
// - Range is plus or minus ten to eighteenth minus one; both zeros valid.
// - Decimal load converts exactly to double extended precision.
// - Masked invalid store writes the decimal indefinite pattern.
// - Floating sign bit: zero positive, one negative, independent of fields.
// - Significand is one integer bit plus fraction; may be implicit.
// - Normalize by shifting left, decrementing exponent per leading zero.
// - Exponents stored biased; single precision bias is 127.
// - Double bias is 1023, double extended bias is 16383.
// - Extended: 15-bit exponent, 63-bit fraction, explicit integer bit.
module bdc_codec (
  input  wire logic           i_clk,
  input  wire logic           i_rst_b,
  input  wire logic [1:0]     i_cmd,
  input  wire logic [79:0]    i_operand,
  input  wire logic           i_invalid_mask,
  input  wire logic [7:0]     i_gpr_byte,
  input  wire logic           i_gpr_packed,
  input  wire logic           i_gpr_muldiv,
  output logic                o_busy,
  output logic                o_done,
  output logic [79:0]         o_result,
  output logic                o_invalid,
  output logic                o_store_suppressed,
  output logic [7:0]          o_gpr_value,
  output logic                o_gpr_invalid,
  output logic [14:0]         o_bias_single,
  output logic [14:0]         o_bias_double,
  output logic [14:0]         o_bias_ext
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    bdc_pkg::bdc_state_t state;
    logic [79:0]         src;
    logic [63:0]         acc;
    logic [14:0]         exp;
    logic                sign;
    logic [4:0]          idx;
    logic                busy;
    logic                done;
    logic [79:0]         result;
    logic                invalid;
    logic                suppressed;
    logic [7:0]          gpr_value;
    logic                gpr_invalid;
    logic [44:0]         bias;
  } bdc_regs_t;

  bdc_regs_t r_q;
  bdc_regs_t r_d;

  logic [7:0] gpr_value;
  logic       gpr_invalid;

  bdc_unpacked_digit i_bdc_unpacked_digit (
    .i_byte    (i_gpr_byte),
    .i_packed  (i_gpr_packed),
    .i_muldiv  (i_gpr_muldiv),
    .o_value   (gpr_value),
    .o_invalid (gpr_invalid)
  );

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // digit position lookup
  function automatic logic [3:0] dec_digit(input logic [79:0] v, input logic [4:0] n);
    dec_digit = v[{n, 2'b00} +: 4];
  endfunction

  function automatic logic [63:0] times_ten(input logic [63:0] v);
    times_ten = {v[60:0], 3'b000} + {v[62:0], 1'b0};
  endfunction

  // Integer of a biased extended value, truncated toward zero; the caller
  // adds the rounding half afterwards.
  function automatic logic [63:0] ext_to_int(input logic [14:0] e, input logic [63:0] s);
    logic [14:0] sh;
    sh = 15'(bdc_pkg::EXT_INT_EXP - e);
    ext_to_int = (sh > 15'h3f) ? 64'h0 : (s >> sh[5:0]);
  endfunction

  logic [63:0] int_mag;
  logic [63:0] bin_rem;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.done = 1'b0;
    r_d.gpr_value = gpr_value;
    r_d.gpr_invalid = gpr_invalid;
    r_d.bias = {bdc_pkg::BIAS_SINGLE, bdc_pkg::BIAS_DOUBLE, bdc_pkg::BIAS_EXT};
    int_mag = 64'h0;
    bin_rem = 64'h0;
    unique case (r_q.state)
      bdc_pkg::BDC_ST_IDLE: begin
        r_d.invalid = 1'b0;
        r_d.suppressed = 1'b0;
        if (i_cmd == bdc_pkg::BDC_CMD_LOAD_DECIMAL) begin
          r_d.src = i_operand;
          r_d.sign = i_operand[bdc_pkg::DEC_SIGN_BIT];
          r_d.acc = 64'h0;
          r_d.idx = bdc_pkg::DIGIT_LAST;
          r_d.busy = 1'b1;
          r_d.state = bdc_pkg::BDC_ST_LOAD;
        end else if (i_cmd == bdc_pkg::BDC_CMD_STORE_DECIMAL_AND_POP) begin
          r_d.src = i_operand;
          r_d.sign = i_operand[79];
          r_d.busy = 1'b1;
          r_d.state = bdc_pkg::BDC_ST_STORE;
        end
      end
      bdc_pkg::BDC_ST_LOAD: begin
        r_d.acc = times_ten(r_q.acc) + 64'(dec_digit(r_q.src, r_q.idx));
        if (r_q.idx == 5'h00) begin
          r_d.exp = bdc_pkg::EXT_INT_EXP;
          r_d.state = bdc_pkg::BDC_ST_NORM;
        end else begin
          r_d.idx = r_q.idx - 5'h01;
        end
      end
      bdc_pkg::BDC_ST_NORM: begin
        if (r_q.acc == 64'h0) begin
          r_d.result = {r_q.sign, 79'h0};
          r_d.busy = 1'b0;
          r_d.done = 1'b1;
          r_d.state = bdc_pkg::BDC_ST_IDLE;
        end else if (!r_q.acc[63]) begin
          r_d.acc = {r_q.acc[62:0], 1'b0};
          r_d.exp = r_q.exp - 15'h0001;
        end else begin
          r_d.result = {r_q.sign, r_q.exp, r_q.acc};
          r_d.busy = 1'b0;
          r_d.done = 1'b1;
          r_d.state = bdc_pkg::BDC_ST_IDLE;
        end
      end
      bdc_pkg::BDC_ST_STORE: begin
        // Round to nearest, ties away from zero, by adding the half bit after truncation.
        int_mag = ext_to_int(r_q.src[78:64], r_q.src[63:0]);
        if (r_q.src[78:64] < bdc_pkg::EXT_INT_EXP && r_q.src[78:64] >= bdc_pkg::BIAS_EXT - 15'h1) begin
          bin_rem = ext_to_int(r_q.src[78:64] + 15'h1, r_q.src[63:0]);
          int_mag = int_mag + 64'(bin_rem[0]);
        end
        if (r_q.src[78:64] == bdc_pkg::EXP_ALL_ONES || r_q.src[78:64] > bdc_pkg::EXT_INT_EXP
            || int_mag > bdc_pkg::DEC_MAX_MAG) begin
          r_d.invalid = 1'b1;
          if (i_invalid_mask) begin
            r_d.result = bdc_pkg::DEC_INDEFINITE;
          end else begin
            r_d.suppressed = 1'b1;
          end
          r_d.busy = 1'b0;
          r_d.done = 1'b1;
          r_d.state = bdc_pkg::BDC_ST_IDLE;
        end else begin
          r_d.acc = int_mag;
          r_d.result = {r_q.sign, 79'h0};
          r_d.idx = 5'h00;
          r_d.state = bdc_pkg::BDC_ST_DONE;
        end
      end
      bdc_pkg::BDC_ST_DONE: begin
        r_d.result[{r_q.idx, 2'b00} +: 4] = 4'(r_q.acc % 64'(bdc_pkg::DIGIT_TEN));
        r_d.acc = r_q.acc / 64'(bdc_pkg::DIGIT_TEN);
        if (r_q.idx == bdc_pkg::DIGIT_LAST) begin
          r_d.busy = 1'b0;
          r_d.done = 1'b1;
          r_d.state = bdc_pkg::BDC_ST_IDLE;
        end else begin
          r_d.idx = r_q.idx + 5'h01;
        end
      end
      default: begin
        r_d.state = bdc_pkg::BDC_ST_IDLE;
        r_d.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_busy             = r_q.busy;
  assign o_done             = r_q.done;
  assign o_result           = r_q.result;
  assign o_invalid          = r_q.invalid;
  assign o_store_suppressed = r_q.suppressed;
  assign o_gpr_value        = r_q.gpr_value;
  assign o_gpr_invalid      = r_q.gpr_invalid;
  assign o_bias_single      = r_q.bias[44:30];
  assign o_bias_double      = r_q.bias[29:15];
  assign o_bias_ext         = r_q.bias[14:0];

endmodule // bdc_codec

// [bdc_codec_properties.sv]
`timescale 1ns/1ps
module bdc_codec_checker (
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic [1:0]  i_cmd,
  input wire logic [79:0] i_operand,
  input wire logic        i_invalid_mask,
  input wire logic [7:0]  i_gpr_byte,
  input wire logic        i_gpr_packed,
  input wire logic        i_gpr_muldiv,
  input wire logic        o_busy,
  input wire logic        o_done,
  input wire logic [79:0] o_result,
  input wire logic        o_invalid,
  input wire logic        o_store_suppressed,
  input wire logic [7:0]  o_gpr_value,
  input wire logic        o_gpr_invalid,
  input wire logic [14:0] o_bias_single,
  input wire logic [14:0] o_bias_double,
  input wire logic [14:0] o_bias_ext
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  wire take_ld = !o_busy && i_cmd == 2'h1;
  wire take_st = !o_busy && i_cmd == 2'h2;
  a_bias_values: assert property ($past(i_rst_b) |-> o_bias_single == 15'h007f &&
    o_bias_double == 15'h03ff && o_bias_ext == 15'h3fff) else $error("bias constant wrong");
  a_load_time: assert property (take_ld |-> ##[20:84] o_done)
    else $error("load done out of range");
  a_zero_load: assert property (take_ld && i_operand[71:0] == 72'h0 |-> ##20 o_done)
    else $error("zero load not twenty cycles");
  a_store_time: assert property (take_st |-> ##2 (o_done && o_invalid) or
    ##20 (o_done && !o_invalid)) else $error("store done timing wrong");
  a_indef_masked: assert property (o_done && o_invalid && !o_store_suppressed |->
    o_result == 80'hffffc000000000000000) else $error("indefinite pattern missing");
  a_suppress_keeps: assert property (o_done && o_store_suppressed |->
    $stable(o_result) && o_invalid) else $error("suppressed store changed result");
  a_unpacked_low: assert property ($past(i_rst_b) && $past(!i_gpr_packed) |->
    o_gpr_value == {4'h0, $past(i_gpr_byte[3:0])}) else $error("unpacked digit wrong");
  a_packed_weight: assert property ($past(i_rst_b) && $past(i_gpr_packed) &&
    $past(i_gpr_byte) <= 8'h99 && $past(i_gpr_byte[3:0]) <= 4'h9 |->
    o_gpr_value == $past(i_gpr_byte[7:4]) * 8'h0a + $past(i_gpr_byte[3:0]))
    else $error("packed digit weight wrong");
  a_digit_range: assert property ($past(i_rst_b) && $past(i_gpr_byte[3:0]) > 4'h9
    |-> o_gpr_invalid) else $error("bad digit not flagged");
  c_load: cover property (take_ld);
  c_store_invalid: cover property (take_st ##2 o_done);
  c_suppressed: cover property (o_done && o_store_suppressed);
endmodule // bdc_codec_checker

bind bdc_codec bdc_codec_checker i_bdc_codec_checker (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_cmd(i_cmd), .i_operand(i_operand), .i_invalid_mask(i_invalid_mask),
  .i_gpr_byte(i_gpr_byte), .i_gpr_packed(i_gpr_packed), .i_gpr_muldiv(i_gpr_muldiv),
  .o_busy(o_busy), .o_done(o_done), .o_result(o_result), .o_invalid(o_invalid),
  .o_store_suppressed(o_store_suppressed), .o_gpr_value(o_gpr_value),
  .o_gpr_invalid(o_gpr_invalid), .o_bias_single(o_bias_single),
  .o_bias_double(o_bias_double), .o_bias_ext(o_bias_ext));

// [bdc_core_model.sv]
`timescale 1ns/1ps
module bdc_core_model (
  input  wire logic        i_clk,
  input  wire logic        i_go,
  input  wire logic [1:0]  i_req_cmd,
  input  wire logic [79:0] i_req_op,
  input  wire logic        i_req_mask,
  input  wire logic        i_busy,
  input  wire logic        i_done,
  output logic      [1:0]  o_cmd,
  output logic      [79:0] o_operand,
  output logic             o_invalid_mask
);
  initial begin
    o_cmd = 2'h0;
    o_operand = '0;
    o_invalid_mask = 1'b0;
  end
  // Operand turns to junk once done so a late read of it cannot pass by luck.
  always @(negedge i_clk) begin
    if (i_go && o_cmd == 2'h0 && !i_busy && !(i_req_cmd == 2'h1 &&
        i_req_op == 80'hffffc000000000000000)) begin
      o_cmd <= i_req_cmd;
      o_operand <= i_req_op;
      o_invalid_mask <= i_req_mask;
    end else begin
      if (i_done) begin
        o_operand <= ~o_operand;
      end
      if (i_busy) begin
        o_cmd <= 2'h0;
      end
    end
  end
endmodule // bdc_core_model

// [bdc_pkg.sv]
package bdc_pkg;

  // ----------------------------------------------------------------------
  // Decimal format layout
  // ----------------------------------------------------------------------
  localparam int unsigned DIGIT_W      = 4;
  localparam int unsigned NUM_DIGITS   = 18;
  localparam int unsigned DEC_W        = 80;
  localparam int unsigned DEC_SIGN_BIT = 79;
  localparam logic [3:0]  DIGIT_MAX    = 4'h9;
  localparam logic [3:0]  DIGIT_TEN    = 4'ha;
  localparam logic [79:0] DEC_INDEFINITE = 80'hffffc000000000000000;
  // Largest magnitude is ten to the eighteenth minus one.
  localparam logic [63:0] DEC_MAX_MAG  = 64'h0de0b6b3a763ffff;

  // ----------------------------------------------------------------------
  // Floating-point formats
  // ----------------------------------------------------------------------
  localparam int unsigned EXT_EXP_W    = 15;
  localparam int unsigned EXT_FRAC_W   = 63;
  localparam int unsigned EXT_W        = 80;
  localparam logic [14:0] BIAS_SINGLE  = 15'h007f;
  localparam logic [14:0] BIAS_DOUBLE  = 15'h03ff;
  localparam logic [14:0] BIAS_EXT     = 15'h3fff;
  localparam logic [14:0] EXP_ALL_ONES = 15'h7fff;
  // Exponent of a significand whose units bit sits at bit 0.
  localparam logic [14:0] EXT_INT_EXP  = 15'h403e;

  // ----------------------------------------------------------------------
  // Commands and states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    BDC_CMD_NONE                  = 2'b00,
    BDC_CMD_LOAD_DECIMAL          = 2'b01,
    BDC_CMD_STORE_DECIMAL_AND_POP = 2'b10
  } bdc_cmd_t;

  typedef enum logic [2:0] {
    BDC_ST_IDLE  = 3'b000,
    BDC_ST_LOAD  = 3'b001,
    BDC_ST_NORM  = 3'b010,
    BDC_ST_STORE = 3'b011,
    BDC_ST_DONE  = 3'b100
  } bdc_state_t;

  localparam logic [4:0] DIGIT_LAST = 5'h11;
  localparam logic [6:0] NORM_STEPS = 7'h40;

endpackage

// [bdc_unpacked_digit.sv]
`timescale 1ns/1ps
// Combinational digit extractor for unpacked and packed decimal bytes.
module bdc_unpacked_digit (
  input  wire logic [7:0] i_byte,
  input  wire logic       i_packed,
  input  wire logic       i_muldiv,
  output logic      [7:0] o_value,
  output logic            o_invalid
);

  logic [3:0] lo_digit;
  logic [3:0] hi_digit;

  always_comb begin
    lo_digit = i_byte[3:0];
    hi_digit = i_byte[7:4];
    o_value  = 8'h00;
    o_invalid = 1'b0;
    if (i_packed) begin
      o_value = 8'({hi_digit, 3'b000}) + 8'({hi_digit, 1'b0}) + 8'(lo_digit);
      o_invalid = (hi_digit > bdc_pkg::DIGIT_MAX) || (lo_digit > bdc_pkg::DIGIT_MAX);
    end else begin
      o_value = 8'(lo_digit);
      o_invalid = (lo_digit > bdc_pkg::DIGIT_MAX) || (i_muldiv && (hi_digit != 4'h0));
    end
  end

endmodule // bdc_unpacked_digit

// [tb_bdc_codec.sv]
`timescale 1ns/1ps
module tb_bdc_codec;
  logic        clk = 1'b0, rst_b = 1'b0, go = 1'b0, rq_mask = 1'b0, g_packed = 1'b0;
  logic        g_muldiv = 1'b0, busy, done, inv, supp, g_inv, m_mask;
  logic [1:0]  rq_cmd = 2'h0, m_cmd;
  logic [7:0]  g_byte = 8'h00, g_val;
  logic [14:0] b_s, b_d, b_e;
  logic [79:0] rq_op = '0, m_op, res;
  int          fail_count = 0, num_checks = 0;

  bdc_core_model i_bdc_core_model (.i_clk(clk), .i_go(go), .i_req_cmd(rq_cmd), .i_req_op(rq_op),
    .i_req_mask(rq_mask), .i_busy(busy), .i_done(done), .o_cmd(m_cmd), .o_operand(m_op),
    .o_invalid_mask(m_mask));
  bdc_codec i_bdc_codec (.i_clk(clk), .i_rst_b(rst_b), .i_cmd(m_cmd), .i_operand(m_op),
    .i_invalid_mask(m_mask), .i_gpr_byte(g_byte), .i_gpr_packed(g_packed),
    .i_gpr_muldiv(g_muldiv), .o_busy(busy), .o_done(done), .o_result(res), .o_invalid(inv),
    .o_store_suppressed(supp), .o_gpr_value(g_val), .o_gpr_invalid(g_inv),
    .o_bias_single(b_s), .o_bias_double(b_d), .o_bias_ext(b_e));
  always #12.5 clk = ~clk;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // A hung operation is counted once and the run carries on.
  task automatic run_op(input logic [1:0] c, input logic [79:0] op, input logic m);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    {rq_cmd, rq_op, rq_mask, go} = {c, op, m, 1'b1};
    while (busy !== 1'b1 && n < 400) begin @(posedge clk); #1; n++; end
    go = 1'b0;
    while (done !== 1'b1 && n < 400) begin @(posedge clk); #1; n++; end
    if (n >= 400) check(80'h0, 80'h1);
  endtask
  function automatic logic [79:0] to_ext(input logic [79:0] d);
    logic [63:0] v;
    int p;
    v = 64'h0;
    p = 63;
    for (int i = 17; i >= 0; i--) v = v * 64'h0a + 64'(d[4*i +: 4]);
    if (v == 64'h0) return {d[79], 79'h0};
    while (!v[63]) begin v = v << 1; p--; end
    return {d[79], 15'(16383 + p), v};
  endfunction

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic test_round_trip();
    logic [79:0] d [5];
    d = '{80'h00000000000000000001, 80'h80999999999999999999, 80'h80000000000000000000,
          80'h7f000000000000000178, 80'h00000000000000000000};
    foreach (d[i]) begin
      run_op(2'h1, d[i], 1'b0);
      check(res, to_ext(d[i]));
      run_op(2'h2, to_ext(d[i]), 1'b1);
      check(res, {d[i][79], 7'h00, d[i][71:0]});
      check(80'(inv), 80'h0);
    end
  endtask
  task automatic test_store_invalid();
    run_op(2'h2, {1'b0, 15'h403e, 64'h8000000000000000}, 1'b1);
    check(res, 80'hffffc000000000000000);
    check(80'(inv), 80'h1);
    run_op(2'h2, {1'b1, 15'h4000, 64'ha000000000000000}, 1'b1);
    check(res, 80'h80000000000000000003);
    run_op(2'h2, {1'b0, 15'h7fff, 64'hc000000000000000}, 1'b0);
    check(res, 80'h80000000000000000003);
    check(80'({supp, inv}), 80'h3);
    run_op(2'h2, {1'b0, 15'h7fff, 64'hc000000000000000}, 1'b1);
    check(res, 80'hffffc000000000000000);
    check(80'(inv), 80'h1);
  endtask
  task automatic test_gpr();
    logic [18:0] t [4];
    t = '{{8'h37, 2'b00, 8'h07, 1'b0}, {8'h37, 2'b01, 8'h07, 1'b1},
          {8'h45, 2'b10, 8'h2d, 1'b0}, {8'h0a, 2'b00, 8'h0a, 1'b1}};
    foreach (t[i]) begin
      @(negedge clk);
      {g_byte, g_packed, g_muldiv} = t[i][18:9];
      @(posedge clk);
      #1;
      check(80'(g_val), 80'(t[i][8:1]));
      check(80'(g_inv), 80'(t[i][0]));
    end
  endtask

  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    @(posedge clk);
    #1;
    check(80'({b_s, b_d, b_e}), 80'({15'h007f, 15'h03ff, 15'h3fff}));
    test_round_trip();
    test_store_invalid();
    test_gpr();
    final_report();
  end
  initial begin
    #(25 * 20000);
    fail_count++;
    final_report();
  end
endmodule // tb_bdc_codec
